// ===== src_checker.sv
// assertions on the standby and reset control ports
`include "src_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module src_checker #(
    parameter NIRQ = 8,
    parameter W    = `SRC_WAIT_W
) (
    input wire            i_sys_clk,
    input wire            i_srst,
    input wire            i_stop_instr,
    input wire            i_halt_instr,
    input wire            i_cpu_on_subclk,
    input wire            i_sio_ext_clk,
    input wire            i_tmr_pin_clk,
    input wire [NIRQ-1:0] i_interrupt_request_flags,
    input wire [NIRQ-1:0] i_interrupt_enable_flags,
    input wire [7:0]      i_vec_byte0,
    input wire [7:0]      i_vec_byte1,
    input wire [1:0]      o_state,
    input wire            o_main_osc_en,
    input wire            o_cpu_clk_en,
    input wire            o_ibt_en,
    input wire            o_sio_en,
    input wire            o_tmr_en,
    input wire [NIRQ-1:0] o_irq_detect_en,
    input wire            o_init_pulse,
    input wire            o_reset_in_standby,
    input wire [13:0]     o_pc_init,
    input wire            o_bank_enable_flag,
    input wire            o_clear_ctrl,
    input wire [7:0]      o_timer_modulo_register
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    wire run = o_state == `SRC_ST_RUN;
    wire sby = o_state == `SRC_ST_HALT || o_state == `SRC_ST_STOP;
    wire [13:0] pc_x = o_reset_in_standby ? {i_vec_byte0[5:0], i_vec_byte1}
                                          : {1'b0, i_vec_byte0[4:0], i_vec_byte1};
    property p_stop; run && i_stop_instr && !i_cpu_on_subclk |=> o_state == 2'h2; endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");
    property p_halt; run && i_halt_instr && !i_stop_instr |=> o_state == 2'h1; endproperty
    a_halt: assert property (p_halt) else $error("halt not taken");
    property p_hgate; o_state == 2'h1 |-> !o_cpu_clk_en && o_main_osc_en; endproperty
    a_hgate: assert property (p_hgate) else $error("halt gating wrong");
    property p_sgate; o_state == 2'h2 |-> !o_main_osc_en && !o_ibt_en
        && o_sio_en == i_sio_ext_clk && o_tmr_en == i_tmr_pin_clk; endproperty
    a_sgate: assert property (p_sgate) else $error("stop gating wrong");
    property p_irq0; sby |-> !o_irq_detect_en[`SRC_IRQ0_BIT]; endproperty
    a_irq0: assert property (p_irq0) else $error("irq zero live");
    property p_wake; sby && |(i_interrupt_request_flags & i_interrupt_enable_flags
        & o_irq_detect_en) |=> o_state == 2'h3; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_wait; o_state == 2'h3 |-> ##[1:1000] run; endproperty
    a_wait: assert property (p_wait) else $error("wait stuck");
    property p_pc; o_init_pulse |-> o_pc_init == pc_x && o_bank_enable_flag == i_vec_byte0[7];
    endproperty
    a_pc: assert property (p_pc) else $error("pc init wrong");
    property p_clr; $fell(i_srst) |-> o_clear_ctrl && o_timer_modulo_register == 8'hFF;
    endproperty
    a_clr: assert property (p_clr) else $error("clear missing");
endmodule
bind src_standby_reset src_checker #(.NIRQ(NIRQ), .W(W)) i_chk (.*);
`default_nettype wire

// ===== src_consts.vh
// constants for the standby and reset control block
// How it works
// (RQ1) stop accepted only on main clock
// (RQ2) halt accepted on either clock
// (RQ3) halt gates CPU clock only
// (RQ4) interval timer stopped in stop mode
// (RQ5) serial runs in stop only with external clock
// (RQ6) event counter runs in stop only with pin
// (RQ7) watch timer in stop needs subsystem clock
// (RQ8) display in stop needs subsystem clock
// (RQ9) irq one two four live, zero dead
// (RQ10) enabled interrupt or reset ends standby
// (RQ11) standby reset loads six-bit high pc
// (RQ12) operating reset loads five-bit high pc
// (RQ13) bank enable from bit seven of byte zero
// (RQ14) standby reset keeps carry, registers, memory
// (RQ15) data locations F8 to FD always lost
// (RQ16) skip, status, bank select cleared on reset
// (RQ17) timer counter cleared, modulo set to FF
// (RQ18) serial control cleared, data kept on standby
// (RQ19) all interrupt flags and modes cleared
// (RQ20) clock and display control registers cleared
// (RQ21) port buffers off, latches and modes cleared
// (RQ22) wake waits settling time before resuming
// (RQ23) remember whether reset came in standby
`ifndef SRC_CONSTS_VH
`define SRC_CONSTS_VH
`define SRC_ST_RUN       2'h0
`define SRC_ST_HALT      2'h1
`define SRC_ST_STOP      2'h2
`define SRC_ST_WAIT      2'h3
`define SRC_VEC_HI_ADDR  14'h0000
`define SRC_VEC_LO_ADDR  14'h0001
`define SRC_MBE_BIT      7
`define SRC_TMOD_RST     8'hFF
`define SRC_UNDEF_LO     9'h0F8
`define SRC_UNDEF_HI     9'h0FD
`define SRC_IRQ0_BIT     0
`define SRC_WAIT_W       20
`endif

// ===== src_partner.sv
// reset pin and wake source model, one register stage like a pin sync
`timescale 1ns/1ps
`default_nettype none
module src_partner (
    input  wire       i_sys_clk,
    input  wire       i_rst_cmd,
    input  wire [7:0] i_irq_cmd,
    output reg        o_srst = 1'b1,
    output reg  [7:0] o_irq = 8'h00
);
    always @(posedge i_sys_clk) begin
        o_srst <= i_rst_cmd;
        o_irq  <= i_irq_cmd;
    end
endmodule
`default_nettype wire

// ===== src_standby_reset.v
// standby mode sequencing and reset initialisation control
`include "src_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module src_standby_reset #(
    parameter NIRQ = 8,
    parameter W    = `SRC_WAIT_W
) (
    // clock and reset
    input  wire            i_sys_clk,
    input  wire            i_srst,
    // cpu instruction strobes, clock state and wait length
    input  wire            i_stop_instr,
    input  wire            i_halt_instr,
    input  wire            i_cpu_on_subclk,
    input  wire [W-1:0]    i_wait_len,
    // peripheral clock selections
    input  wire            i_sio_ext_clk,
    input  wire            i_tmr_pin_clk,
    input  wire            i_watch_subclk,
    input  wire            i_display_clock_source,
    // interrupt requests and enables
    input  wire [NIRQ-1:0] i_interrupt_request_flags,
    input  wire [NIRQ-1:0] i_interrupt_enable_flags,
    // program memory bytes at vector addresses
    input  wire [7:0]      i_vec_byte0,
    input  wire [7:0]      i_vec_byte1,
    // standby status and clock gates
    output reg  [1:0]      o_state,
    output reg             o_main_osc_en,
    output reg             o_cpu_clk_en,
    output reg             o_ibt_en,
    output reg             o_sio_en,
    output reg             o_tmr_en,
    output reg             o_watch_en,
    output reg             o_lcd_en,
    output reg  [NIRQ-1:0] o_irq_detect_en,
    // reset results
    output reg             o_init_pulse,
    output reg             o_reset_in_standby,
    output reg  [13:0]     o_pc_init,
    output reg             o_bank_enable_flag,
    output reg             o_retain_core,
    output reg             o_retain_serial_data,
    output reg  [8:0]      o_undef_lo,
    output reg  [8:0]      o_undef_hi,
    output reg             o_clear_ctrl,
    output reg  [7:0]      o_timer_modulo_register
);
    reg [1:0]  state_q;
    reg [1:0]  state_d;
    reg        was_sb_q;
    reg        in_rst_q;
    wire       wait_done;
    wire       wake;
    wire [1:0] st_cmb;
    wire       main_run;

    // any enabled request ends standby, irq zero cannot act during stop/halt
    assign wake = |(i_interrupt_request_flags & i_interrupt_enable_flags &
                    o_irq_detect_en); // RQ10

    always @* begin
        state_d = state_q;
        case (state_q)
            `SRC_ST_RUN: begin
                if (i_stop_instr && !i_cpu_on_subclk)
                    state_d = `SRC_ST_STOP; // RQ1
                else if (i_halt_instr)
                    state_d = `SRC_ST_HALT; // RQ2
            end
            `SRC_ST_HALT: begin
                if (wake)
                    state_d = `SRC_ST_WAIT; // RQ10
            end
            `SRC_ST_STOP: begin
                if (wake)
                    state_d = `SRC_ST_WAIT; // RQ10
            end
            `SRC_ST_WAIT: begin
                if (wait_done)
                    state_d = `SRC_ST_RUN; // RQ22
            end
            default: state_d = `SRC_ST_RUN;
        endcase
    end

    assign st_cmb   = i_srst ? `SRC_ST_RUN : state_d;
    assign main_run = (st_cmb != `SRC_ST_STOP);

    src_wait_cnt #(.W(W)) u_wait (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_start   ((state_q == `SRC_ST_HALT || state_q == `SRC_ST_STOP) && wake),
        .i_len     (i_wait_len),
        .o_done    (wait_done)
    );

    genvar g;
    generate
        for (g = 0; g < NIRQ; g = g + 1) begin : g_irq
            always @(posedge i_sys_clk) begin
                if (i_srst)
                    o_irq_detect_en[g] <= 1'b1;
                else if (g == `SRC_IRQ0_BIT)
                    o_irq_detect_en[g] <= (st_cmb == `SRC_ST_RUN) ||
                                          (st_cmb == `SRC_ST_WAIT); // RQ9
                else
                    o_irq_detect_en[g] <= 1'b1; // RQ9
            end
        end
    endgenerate

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_q       <= `SRC_ST_RUN;
            o_state       <= `SRC_ST_RUN;
            o_main_osc_en <= 1'b1;
            o_cpu_clk_en  <= 1'b0;
            o_ibt_en      <= 1'b1;
            o_sio_en      <= 1'b1;
            o_tmr_en      <= 1'b1;
            o_watch_en    <= 1'b1;
            o_lcd_en      <= 1'b1;
        end else begin
            state_q       <= state_d;
            o_state       <= state_d;
            o_main_osc_en <= main_run; // RQ1
            o_cpu_clk_en  <= (state_d == `SRC_ST_RUN); // RQ3
            o_ibt_en      <= main_run; // RQ4
            o_sio_en      <= main_run || i_sio_ext_clk; // RQ5
            o_tmr_en      <= main_run || i_tmr_pin_clk; // RQ6
            o_watch_en    <= main_run || i_watch_subclk; // RQ7
            o_lcd_en      <= main_run || i_display_clock_source; // RQ8
        end
    end

    // standby state seen at the reset edge decides the init flavour;
    // captured each cycle outside reset so it is valid when the reset pin first rises
    always @(posedge i_sys_clk) begin
        in_rst_q <= i_srst;
        if (!in_rst_q)
            was_sb_q <= (state_q == `SRC_ST_HALT) || (state_q == `SRC_ST_STOP); // RQ23
    end

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_init_pulse         <= 1'b0;
            o_reset_in_standby   <= 1'b0;
            o_pc_init            <= 14'h0000;
            o_bank_enable_flag   <= 1'b0;
            o_retain_core        <= 1'b0;
            o_retain_serial_data <= 1'b0;
            o_undef_lo           <= `SRC_UNDEF_LO;
            o_undef_hi           <= `SRC_UNDEF_HI;
            o_clear_ctrl         <= 1'b1;
            o_timer_modulo_register <= `SRC_TMOD_RST; // RQ17
        end else begin
            o_init_pulse <= in_rst_q;
            o_clear_ctrl <= 1'b0;
            if (in_rst_q) begin
                // unknown capture at power-up falls to the operating flavour
                if (was_sb_q) begin
                    o_reset_in_standby   <= 1'b1; // RQ23
                    o_pc_init            <= {i_vec_byte0[5:0], i_vec_byte1}; // RQ11
                    o_retain_core        <= 1'b1; // RQ14
                    o_retain_serial_data <= 1'b1; // RQ18
                end else begin
                    o_reset_in_standby   <= 1'b0; // RQ23
                    o_pc_init            <= {1'b0, i_vec_byte0[4:0], i_vec_byte1}; // RQ12
                    o_retain_core        <= 1'b0; // RQ14
                    o_retain_serial_data <= 1'b0; // RQ18
                end
                o_bank_enable_flag   <= i_vec_byte0[`SRC_MBE_BIT]; // RQ13
            end
        end
    end
    // RQ15 RQ16 RQ19 RQ20 RQ21: o_clear_ctrl high through reset, o_undef_* fixed
endmodule
`default_nettype wire

// ===== src_wait_cnt.v
// settling wait counter run after standby release
`include "src_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module src_wait_cnt #(
    parameter W = `SRC_WAIT_W
) (
    // clock and reset
    input  wire         i_sys_clk,
    input  wire         i_srst,
    // control
    input  wire         i_start,
    input  wire [W-1:0] i_len,
    output reg          o_done
);
    reg [W-1:0] cnt_q;
    reg         run_q;
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            cnt_q  <= {W{1'b0}};
            run_q  <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                cnt_q <= i_len;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (cnt_q == {W{1'b0}}) begin
                    run_q  <= 1'b0;
                    o_done <= 1'b1; // RQ22
                end else begin
                    cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== standby_reset_control_tb_top.sv
// self-checking bench for the standby and reset control block
`timescale 1ns/1ps
`default_nettype none
module standby_reset_control_tb_top;
    reg i_sys_clk = 1'b0, rst_cmd = 1'b1, i_stop_instr = 1'b0, i_halt_instr = 1'b0;
    reg i_cpu_on_subclk = 1'b0, i_sio_ext_clk = 1'b1, i_tmr_pin_clk = 1'b0;
    reg [7:0] irq_cmd = 8'h00, i_interrupt_enable_flags = 8'h00;
    reg [7:0] i_vec_byte0 = 8'hA5, i_vec_byte1 = 8'h3C;
    wire [19:0] i_wait_len = 20'h00003;
    wire i_watch_subclk = 1'b1, i_display_clock_source = 1'b0, i_srst;
    wire [7:0] i_interrupt_request_flags, o_irq_detect_en, o_timer_modulo_register;
    wire [1:0] o_state;
    wire o_main_osc_en, o_cpu_clk_en, o_ibt_en, o_sio_en, o_tmr_en, o_watch_en, o_lcd_en;
    wire o_init_pulse, o_reset_in_standby, o_bank_enable_flag, o_retain_core;
    wire o_retain_serial_data, o_clear_ctrl;
    wire [13:0] o_pc_init;
    wire [8:0] o_undef_lo, o_undef_hi;
    integer n_errors = 0, checked = 0, cyc = 0;
    always #12.5 i_sys_clk = ~i_sys_clk;
    src_partner i_far (.i_sys_clk(i_sys_clk), .i_rst_cmd(rst_cmd), .i_irq_cmd(irq_cmd),
        .o_srst(i_srst), .o_irq(i_interrupt_request_flags));
    src_standby_reset i_dut (.*);
    task chk(input [17:0] got, input [17:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task go(input integer n);
        begin
            repeat (n) @(posedge i_sys_clk);
            #1;
        end
    endtask
    task t_reset(input sb);
        begin
            @(posedge i_sys_clk) rst_cmd <= 1'b1;
            @(posedge i_sys_clk) rst_cmd <= 1'b0;
            go(4);
            chk(o_pc_init, sb ? 14'h253C : 14'h053C);
            chk(o_bank_enable_flag, 1'b1);
            chk({o_retain_core, o_retain_serial_data, o_reset_in_standby}, {3{sb}});
            chk({o_undef_lo, o_undef_hi}, {9'h0F8, 9'h0FD});
            chk(o_timer_modulo_register, 8'hFF);
            $display("reset test done");
        end
    endtask
    task t_halt;
        begin
            @(posedge i_sys_clk);
            i_cpu_on_subclk <= 1'b1;
            i_halt_instr <= 1'b1;
            i_interrupt_enable_flags <= 8'hFF;
            @(posedge i_sys_clk) i_halt_instr <= 1'b0;
            #1 chk({o_state, o_cpu_clk_en, o_main_osc_en}, 4'h5);
            // zero alone must not wake even when enabled
            @(posedge i_sys_clk) irq_cmd <= 8'h01;
            go(4);
            chk(o_state, 2'h1);
            @(posedge i_sys_clk) irq_cmd <= 8'h03;
            go(3);
            chk(o_state, 2'h3);
            go(10);
            chk({o_state, o_cpu_clk_en}, 3'h1);
            irq_cmd <= 8'h00;
            i_cpu_on_subclk <= 1'b0;
            $display("halt test done");
        end
    endtask
    task t_stop;
        begin
            @(posedge i_sys_clk);
            i_cpu_on_subclk <= 1'b1;
            i_stop_instr <= 1'b1;
            go(1);
            chk(o_state, 2'h0);
            @(posedge i_sys_clk) i_cpu_on_subclk <= 1'b0;
            @(posedge i_sys_clk) i_stop_instr <= 1'b0;
            #1 chk({o_state, o_main_osc_en, o_ibt_en, o_sio_en, o_tmr_en, o_watch_en, o_lcd_en},
                8'h8A);
            $display("stop test done");
            t_reset(1'b1);
        end
    endtask
    task give_verdict;
        begin
            $display("checked %0d n_errors %0d", checked, n_errors);
            if (n_errors == 0 && checked > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    always @(posedge i_sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            n_errors = n_errors + 1;
            $display("BAD %0t run too long", $time);
            give_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge i_sys_clk);
        rst_cmd <= 1'b0;
        go(3);
        t_reset(1'b0);
        t_halt;
        t_stop;
        give_verdict;
    end
endmodule
`default_nettype wire
